// file: logic/opv_bit_if.sv
// interface: edge events to the bit measurer and bit decisions back
`timescale 1ns/1ps
interface opv_bit_if;
    logic fall;   // falling edge seen on the line
    logic rise;   // rising edge seen on the line
    logic first;  // this fall opens a byte, nothing to decide
    logic done;   // one-cycle pulse, a bit has ended
    logic value;  // decided bit value
    logic bad;    // neither ratio held
    modport ctrl (output fall, rise, first, input done, value, bad);
    modport meas (input fall, rise, first, output done, value, bad);
endinterface

// file: logic/opv_bit_meas.sv
// bit measurer: times low and high phases and decides each bit
`timescale 1ns/1ps
module opv_bit_meas #(
    parameter int CNT_W = opv_pkg::CNT_W
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // edge events in, decisions out
    opv_bit_if.meas ch
);
    import opv_pkg::*;

    logic [CNT_W-1:0] low_cnt_r;
    logic [CNT_W-1:0] high_cnt_r;
    logic in_high_r;
    logic is_one;
    logic is_zero;

    // ------------------------------------------------------------------
    // phase counters
    // ------------------------------------------------------------------
    // counts saturate so a very slow host cannot wrap into a wrong ratio
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            low_cnt_r <= '0;
            high_cnt_r <= '0;
            in_high_r <= 1'b0;
        end else if (ch.fall) begin
            low_cnt_r <= '0;
            high_cnt_r <= '0;
            in_high_r <= 1'b0;
        end else if (ch.rise) begin
            in_high_r <= 1'b1;
        end else if (in_high_r) begin
            if (high_cnt_r != '1) high_cnt_r <= high_cnt_r + 1'b1;
        end else begin
            if (low_cnt_r != '1) low_cnt_r <= low_cnt_r + 1'b1;
        end
    end

    // ratio test: one needs high at least twice low, zero the reverse
    assign is_one = {1'b0, high_cnt_r} >= {low_cnt_r, 1'b0};
    assign is_zero = {1'b0, low_cnt_r} >= {high_cnt_r, 1'b0};

    // ------------------------------------------------------------------
    // decision, one cycle after the closing fall
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ch.done <= 1'b0;
            ch.value <= 1'b0;
            ch.bad <= 1'b0;
        end else begin
            ch.done <= ch.fall & ~ch.first;
            ch.value <= is_one;
            ch.bad <= ~is_one & ~is_zero;
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    one_bit_a: assert property (@(posedge clk) disable iff (!reset_n)
        ch.fall && !ch.first && is_one |=> ch.done && ch.value && !ch.bad)
        else $error("long high phase not decoded as one");
    zero_bit_a: assert property (@(posedge clk) disable iff (!reset_n)
        ch.fall && !ch.first && !is_one && is_zero
        |=> ch.done && !ch.value && !ch.bad)
        else $error("long low phase not decoded as zero");
    count_reset_a: assert property (@(posedge clk) disable iff (!reset_n)
        ch.fall |=> low_cnt_r == '0 && high_cnt_r == '0 && !in_high_r)
        else $error("phase counters not restarted at fall");

endmodule // opv_bit_meas

// file: logic/opv_pkg.sv
// package: constants and types of the one-pin voltage configuration receiver
package opv_pkg;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 8;
    localparam int PS_DELAY_US = 520;   // power_save_delay, longest
    localparam int ACK_PULSE_US = 520;  // ack_pulse_time, longest
    localparam int ACK_VALID_US = 10;   // ack_valid_delay
    // longest times round down to whole cycles
    localparam int PS_DELAY_CYC = PS_DELAY_US * 1000 / CLK_PERIOD_NS;
    localparam int ACK_PULSE_CYC = ACK_PULSE_US * 1000 / CLK_PERIOD_NS;
    localparam int ACK_VALID_CYC = ACK_VALID_US * 1000 / CLK_PERIOD_NS;
    localparam int TMR_W = 17;          // timeout and ack counters
    localparam int CNT_W = 18;          // phase counters, saturate after 2.1 ms per phase

    // ------------------------------------------------------------------
    // frame layout
    // ------------------------------------------------------------------
    localparam logic [7:0] DEV_ADDR = 8'h4E;
    localparam logic [3:0] ADDR_LAST_BIT = 4'h7;
    localparam logic [3:0] FRAME_LAST_BIT = 4'hF;
    localparam int ACK_REQ_POS = 7;
    localparam int SEL_HI_POS = 6;
    localparam int SEL_LO_POS = 5;
    localparam int CODE_HI_POS = 4;
    localparam logic [1:0] SEL_CONV1 = 2'h1;
    localparam logic [1:0] SEL_CONV2 = 2'h2;
    localparam logic [4:0] CODE_RESET = 5'h00;
    localparam logic [4:0] CODE_DEFAULT = 5'h00;

    // ------------------------------------------------------------------
    // converter 1 target table: base plus step per code
    // ------------------------------------------------------------------
    localparam int MV_W = 11;
    localparam logic [MV_W-1:0] VOLT_BASE_MV = 11'h320;  // 800 mV
    localparam logic [MV_W-1:0] VOLT_STEP_MV = 11'h019;  // 25 mV

    typedef enum logic [2:0] {
        OPV_IDLE = 3'b000,
        OPV_BIT = 3'b001,
        OPV_GAP = 3'b010,
        OPV_WAIT_ACK = 3'b011,
        OPV_ACK = 3'b100
    } opv_state_t;

endpackage

// file: logic/opv_rx.sv
// top: mode/data pin receiver with mode select, frame decode and ack
`timescale 1ns/1ps
module opv_rx #(
    parameter int PS_DELAY_CYC = opv_pkg::PS_DELAY_CYC,
    parameter int ACK_PULSE_CYC = opv_pkg::ACK_PULSE_CYC,
    parameter int ACK_VALID_CYC = opv_pkg::ACK_VALID_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // mode/data pin, open drain
    input wire logic line_in,
    output logic line_out,
    output logic line_oe,
    // converter mode control
    output logic forced_pwm,
    output logic power_save_en,
    // converter 1 setting
    output logic [4:0] conv1_code,
    output logic conv1_default_sel,
    output logic [opv_pkg::MV_W-1:0] conv1_target_mv,
    // converter 2 setting, code passed on raw
    output logic [4:0] conv2_code,
    // frame status pulses
    output logic frame_ok,
    output logic frame_err
);
    import opv_pkg::*;

    // converter 1 target in mV, zero when the external network rules
    function automatic logic [MV_W-1:0] opv_target_mv(input logic [4:0] c);
        if (c == CODE_DEFAULT) return '0;
        return VOLT_BASE_MV + VOLT_STEP_MV * {6'h00, c};
    endfunction

    opv_state_t state_r;
    logic line_prev_r;
    logic fall;
    logic rise;
    logic [TMR_W-1:0] low_cnt_r;
    logic [TMR_W-1:0] tmr_r;
    logic ack_phase;
    logic ps_hit;
    logic mode_pwm_r;
    logic [3:0] bit_cnt_r;
    logic [15:0] shift_r;
    logic [7:0] frame_data;
    logic byte1_end;
    logic frame_end;
    logic addr_ok;
    logic ack_req_r;

    opv_bit_if bit_ch ();

    // ------------------------------------------------------------------
    // edge detection and bit measurer
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) line_prev_r <= 1'b0;
        else line_prev_r <= line_in;
    end

    assign fall = line_prev_r & ~line_in;
    assign rise = ~line_prev_r & line_in;
    assign bit_ch.fall = fall;
    assign bit_ch.rise = rise;
    // a fall in idle or after a start opens a byte instead of ending a bit
    assign bit_ch.first = (state_r == OPV_IDLE) || (state_r == OPV_GAP);

    opv_bit_meas #(.CNT_W(CNT_W)) u_meas (
        .clk(clk),
        .reset_n(reset_n),
        .ch(bit_ch.meas)
    );

    // ------------------------------------------------------------------
    // low-time counter and mode selection
    // ------------------------------------------------------------------
    // our own ack pull, and the host hold before it, must not time out
    assign ack_phase = (state_r == OPV_WAIT_ACK) || (state_r == OPV_ACK);
    assign ps_hit = !line_in && !ack_phase
        && low_cnt_r == TMR_W'(PS_DELAY_CYC - 1);

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) low_cnt_r <= '0;
        else if (line_in || ack_phase) low_cnt_r <= '0;
        else if (low_cnt_r != TMR_W'(PS_DELAY_CYC))
            low_cnt_r <= low_cnt_r + 1'b1;
    end

    // grounded pin at reset means power save until the line rises
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) mode_pwm_r <= 1'b0;
        else if (line_in) mode_pwm_r <= 1'b1;
        else if (ps_hit) mode_pwm_r <= 1'b0;
    end

    // the raw line term makes the switch to fixed frequency immediate
    assign forced_pwm = line_in | mode_pwm_r
        | (state_r != OPV_IDLE);
    assign power_save_en = ~forced_pwm;

    // ------------------------------------------------------------------
    // frame receiver
    // ------------------------------------------------------------------
    assign frame_data = {shift_r[6:0], bit_ch.value};
    assign byte1_end = state_r == OPV_BIT && bit_ch.done && !bit_ch.bad
        && bit_cnt_r == ADDR_LAST_BIT;
    assign frame_end = state_r == OPV_BIT && bit_ch.done && !bit_ch.bad
        && bit_cnt_r == FRAME_LAST_BIT;
    // the last bit has not shifted in yet, so the address sits one lower
    assign addr_ok = shift_r[14:7] == DEV_ADDR;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= OPV_IDLE;
            bit_cnt_r <= 4'h0;
            shift_r <= 16'h0000;
            tmr_r <= '0;
        end else begin
            case (state_r)
                OPV_IDLE: begin
                    bit_cnt_r <= 4'h0;
                    if (fall) state_r <= OPV_BIT;
                end
                OPV_BIT: begin
                    if (ps_hit || (bit_ch.done && bit_ch.bad)) begin
                        state_r <= OPV_IDLE;
                    end else if (bit_ch.done) begin
                        shift_r <= {shift_r[14:0], bit_ch.value};
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                        if (byte1_end) begin
                            // misframed or foreign address: drop it
                            if (frame_data != DEV_ADDR)
                                state_r <= OPV_IDLE;
                            else
                                state_r <= OPV_GAP;
                        end else if (frame_end) begin
                            tmr_r <= '0;
                            if (addr_ok && frame_data[ACK_REQ_POS])
                                state_r <= OPV_WAIT_ACK;
                            else
                                state_r <= OPV_IDLE;
                        end
                    end
                end
                OPV_GAP: begin
                    // end-of-byte low, then start high; next fall opens byte
                    if (ps_hit) state_r <= OPV_IDLE;
                    else if (fall) state_r <= OPV_BIT;
                end
                OPV_WAIT_ACK: begin
                    if (tmr_r == TMR_W'(ACK_VALID_CYC - 1)) begin
                        tmr_r <= '0;
                        state_r <= OPV_ACK;
                    end else begin
                        tmr_r <= tmr_r + 1'b1;
                    end
                end
                OPV_ACK: begin
                    if (tmr_r == TMR_W'(ACK_PULSE_CYC - 1)) begin
                        tmr_r <= '0;
                        state_r <= OPV_IDLE;
                    end else begin
                        tmr_r <= tmr_r + 1'b1;
                    end
                end
                default: state_r <= OPV_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // register write and status
    // ------------------------------------------------------------------
    // select codes 00 and 11 are accepted but store no converter code
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            conv1_code <= CODE_RESET;
            conv2_code <= CODE_RESET;
            ack_req_r <= 1'b0;
        end else if (frame_end && addr_ok) begin
            ack_req_r <= frame_data[ACK_REQ_POS];
            case (frame_data[SEL_HI_POS:SEL_LO_POS])
                SEL_CONV1: conv1_code <= frame_data[CODE_HI_POS:0];
                SEL_CONV2: conv2_code <= frame_data[CODE_HI_POS:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            frame_ok <= 1'b0;
            frame_err <= 1'b0;
        end else begin
            frame_ok <= frame_end && addr_ok;
            frame_err <= (state_r == OPV_BIT || state_r == OPV_GAP)
                && (ps_hit || (bit_ch.done && bit_ch.bad)
                || (byte1_end && frame_data != DEV_ADDR));
        end
    end

    assign conv1_default_sel = conv1_code == CODE_DEFAULT;
    assign conv1_target_mv = opv_target_mv(conv1_code);
    // open drain: only ever pulls low, the host pull-up returns it high
    assign line_out = 1'b0;
    assign line_oe = state_r == OPV_ACK;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    sequence s_addr_bad;
        byte1_end ##0 (frame_data != DEV_ADDR);
    endsequence
    sequence s_conv1_write;
        frame_end ##0 addr_ok ##0 (frame_data[6:5] == SEL_CONV1);
    endsequence

    line_pwm_a: assert property (@(posedge clk) disable iff (!reset_n)
        line_in |-> forced_pwm && !power_save_en)
        else $error("high line without forced pwm");
    frame_pwm_a: assert property (@(posedge clk) disable iff (!reset_n)
        state_r != OPV_IDLE |-> forced_pwm)
        else $error("power save during frame");
    bit_start_a: assert property (@(posedge clk) disable iff (!reset_n)
        state_r == OPV_IDLE && fall |=> state_r == OPV_BIT)
        else $error("fall in idle did not start a bit");
    ps_bound_a: assert property (@(posedge clk) disable iff (!reset_n)
        !line_in && low_cnt_r == TMR_W'(PS_DELAY_CYC) |-> power_save_en)
        else $error("power save late after long low");
    timeout_abort_a: assert property (@(posedge clk) disable iff (!reset_n)
        ps_hit |=> !mode_pwm_r && state_r == OPV_IDLE)
        else $error("timeout did not end frame");
    addr_drop_a: assert property (@(posedge clk) disable iff (!reset_n)
        s_addr_bad |=> state_r == OPV_IDLE ##1 frame_ok == 1'b0)
        else $error("foreign address not dropped");
    code_store_a: assert property (@(posedge clk) disable iff (!reset_n)
        s_conv1_write |=> conv1_code == $past(shift_r[3:0]) * 2
            + 5'($past(bit_ch.value)))
        else $error("converter 1 code stored wrongly");
    ack_cause_a: assert property (@(posedge clk) disable iff (!reset_n)
        line_oe |-> ack_req_r && !line_out && shift_r[15:8] == DEV_ADDR)
        else $error("ack driven without request");
    ack_start_a: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(line_oe) |-> $past(state_r) == OPV_WAIT_ACK
            && $past(tmr_r) == TMR_W'(ACK_VALID_CYC - 1))
        else $error("ack began at wrong time");
    ack_len_a: assert property (@(posedge clk) disable iff (!reset_n)
        line_oe |-> tmr_r < TMR_W'(ACK_PULSE_CYC))
        else $error("ack pulse too long");
    volt_map_a: assert property (@(posedge clk) disable iff (!reset_n)
        conv1_code != 5'h00 |-> conv1_target_mv
            == 11'd800 + 11'd25 * {6'h00, conv1_code} && !conv1_default_sel)
        else $error("converter 1 target wrong");

endmodule // opv_rx

// file: testbench/opv_host.sv
// host model: open-drain pulse-width coded sender on the mode/data pin
`timescale 1ns/1ps
module opv_host #(
    parameter int BIT_T = 8  // short phase of a bit, in clock cycles
) (
    // clock
    input wire logic clk,
    // pin, open drain: the host only ever pulls low
    output logic pull_low = 1'b1
);
    // ------------------------------------------------------------------
    // line primitives, always entered on a falling clock edge
    // ------------------------------------------------------------------
    // release lets the bench pull-up take the line high
    task automatic drive(input logic low, input int cyc);
        pull_low = low;
        repeat (cyc) @(negedge clk);
    endtask

    // one bit from fall to fall; a 3:1 ratio leaves margin over 2:1
    task automatic send_bit(input int lo, input int hi);
        drive(1'b1, lo);
        drive(1'b0, hi);
    endtask

    // start high, eight bits msb first, closing fall held as end of stream
    task automatic send_byte(input logic [7:0] b, input int eos);
        drive(1'b0, 2 * BIT_T);
        for (int i = 7; i >= 0; i--) begin
            if (b[i]) begin
                send_bit(BIT_T, 3 * BIT_T);
            end else begin
                send_bit(3 * BIT_T, BIT_T);
            end
        end
        drive(1'b1, eos);
    endtask

    // whole frame first, then the line stays low so power save may follow
    task automatic send_frame(input logic [7:0] addr, input logic [7:0] dat);
        send_byte(addr, 2 * BIT_T);
        send_byte(dat, 0);
    endtask
endmodule // opv_host

// file: testbench/test_opv_rx.sv
// bench: self-checking test of the one-pin voltage configuration receiver
`timescale 1ns/1ps
module test_opv_rx;
    import opv_pkg::*;

    // ------------------------------------------------------------------
    // shortened counts and signals
    // ------------------------------------------------------------------
    localparam int PS_CYC = 200;
    localparam int PULSE_CYC = 50;
    localparam int VALID_CYC = 20;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic pull_low;
    wire logic line_in;
    logic line_out, line_oe, forced_pwm, power_save_en;
    logic [4:0] conv1_code, conv2_code;
    logic conv1_default_sel, frame_ok, frame_err;
    logic [MV_W-1:0] conv1_target_mv;
    logic [4:0] exp1 = 5'h00;
    logic [4:0] exp2 = 5'h00;
    int failures = 0;
    int tests_run = 0;
    int ok_cnt = 0;
    int err_cnt = 0;

    always #4 clk = ~clk;
    // wired line: either party may pull low, the pull-up wins otherwise
    assign line_in = ~(pull_low | (line_oe & ~line_out));

    opv_host host (.clk(clk), .pull_low(pull_low));
    opv_rx #(.PS_DELAY_CYC(PS_CYC), .ACK_PULSE_CYC(PULSE_CYC),
        .ACK_VALID_CYC(VALID_CYC)) DUT (
        .clk(clk), .reset_n(reset_n), .line_in(line_in),
        .line_out(line_out), .line_oe(line_oe), .forced_pwm(forced_pwm),
        .power_save_en(power_save_en), .conv1_code(conv1_code),
        .conv1_default_sel(conv1_default_sel),
        .conv1_target_mv(conv1_target_mv), .conv2_code(conv2_code),
        .frame_ok(frame_ok), .frame_err(frame_err));

    // status pulses last one cycle, so count them on every rising edge
    always @(posedge clk) begin
        if (frame_ok === 1'b1) ok_cnt++;
        if (frame_err === 1'b1) err_cnt++;
    end

    // ------------------------------------------------------------------
    // compare and report helpers
    // ------------------------------------------------------------------
    task automatic chk_val(input logic [10:0] got, input logic [10:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        chk_val({10'h000, got}, {10'h000, exp});
    endtask

    task automatic end_test(input string name);
        $display("test %s done", name);
    endtask

    task automatic complete_run();
        $display("tests_run=%0d failures=%0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // k counts edges after the closing fall; rel is when the host lets go
    task automatic watch(input int lim, input int rel, output int ok_k,
        output int oe_k, output int oe_len);
        ok_k = -1;
        oe_k = -1;
        oe_len = 0;
        for (int k = 0; k < lim; k++) begin
            @(negedge clk);
            if (k == 0) chk_bit(forced_pwm, 1'b1);
            if (k == rel) host.drive(1'b0, 0);
            if (k == rel + 1) chk_bit(line_in, 1'b0);
            if (ok_k < 0 && frame_ok === 1'b1) ok_k = k;
            if (line_oe === 1'b1) begin
                if (oe_k < 0) oe_k = k;
                oe_len++;
            end
        end
    endtask

    // settings against the code table, worked out from base and step
    task automatic chk_codes();
        logic [10:0] mv;
        mv = (exp1 == 5'h00) ? 11'h000 : 11'h339 + 11'h019 * 11'(exp1 - 5'h01);
        chk_val(11'(conv1_code), 11'(exp1));
        chk_bit(conv1_default_sel, exp1 == 5'h00);
        chk_val(conv1_target_mv, mv);
        chk_val(11'(conv2_code), 11'(exp2));
    endtask

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_reset();
        chk_bit(line_oe, 1'b0);
        chk_bit(power_save_en, 1'b1);
        chk_codes();
        end_test("reset");
    endtask

    // high forces the mode at once; a long low times out to power save
    task automatic t_mode();
        int k;
        int e0;
        host.drive(1'b0, 0);
        #1 chk_bit(forced_pwm, 1'b1);
        repeat (10) @(negedge clk);
        e0 = err_cnt;
        host.drive(1'b1, 0);
        k = 0;
        while (power_save_en !== 1'b1 && k < PS_CYC + 20) begin
            @(negedge clk);
            k++;
            if (k == PS_CYC - 10) chk_bit(forced_pwm, 1'b1);
        end
        chk_bit(k >= PS_CYC && k <= PS_CYC + 3, 1'b1);
        chk_bit(forced_pwm, 1'b0);
        // the abort pulse is only counted at the next rising edge
        @(negedge clk);
        chk_bit(err_cnt == e0 + 1, 1'b1);
        end_test("mode");
    endtask

    // every select value, code boundaries, no ack asked
    task automatic t_frames();
        logic [7:0] dat [7] = '{8'h20, 8'h21, 8'h30, 8'h3F, 8'h55, 8'h7A,
            8'h0C};
        int ok_k, oe_k, oe_len;
        foreach (dat[i]) begin
            host.send_frame(8'h4E, dat[i]);
            watch(40, -1, ok_k, oe_k, oe_len);
            if (dat[i][6:5] == 2'b01) exp1 = dat[i][4:0];
            if (dat[i][6:5] == 2'b10) exp2 = dat[i][4:0];
            chk_bit(ok_k == 1, 1'b1);
            chk_bit(oe_k == -1, 1'b1);
            chk_codes();
        end
        end_test("frames");
    endtask

    // ack: host holds low through the delay, device then pulls low
    task automatic t_ack();
        int ok_k, oe_k, oe_len;
        host.send_frame(8'h4E, 8'hA9);
        watch(VALID_CYC + PULSE_CYC + 30, VALID_CYC + 4, ok_k, oe_k, oe_len);
        exp1 = 5'h09;
        chk_bit(ok_k == 1, 1'b1);
        chk_bit(oe_k == VALID_CYC + 1, 1'b1);
        chk_bit(oe_len == PULSE_CYC, 1'b1);
        chk_bit(line_in, 1'b1);
        chk_codes();
        end_test("ack");
    endtask

    // wrong address with ack asked, then a bit with no clear ratio
    task automatic t_refuse();
        int ok_k, oe_k, oe_len;
        int o0, e0;
        o0 = ok_cnt;
        e0 = err_cnt;
        host.send_frame(8'h4F, 8'hB3);
        watch(60, -1, ok_k, oe_k, oe_len);
        chk_bit(oe_k == -1 && ok_cnt == o0, 1'b1);
        chk_bit(err_cnt > e0, 1'b1);
        chk_codes();
        e0 = err_cnt;
        host.drive(1'b0, 16);
        host.send_bit(12, 12);
        host.drive(1'b1, 8);
        chk_bit(err_cnt == e0 + 1, 1'b1);
        chk_bit(ok_cnt == o0, 1'b1);
        end_test("refuse");
    endtask

    // frame sent while the mode change low is still pending
    task automatic t_pending();
        int ok_k, oe_k, oe_len;
        int o0;
        host.drive(1'b0, 20);
        host.drive(1'b1, 20);
        o0 = ok_cnt;
        host.send_frame(8'h4E, 8'h2A);
        watch(40, -1, ok_k, oe_k, oe_len);
        chk_bit(ok_cnt == o0, 1'b1);
        chk_codes();
        end_test("pending");
    endtask

    // ------------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------------
    initial begin
        repeat (4) @(negedge clk);
        reset_n = 1'b1;
        repeat (2) @(negedge clk);
        t_reset();
        t_mode();
        t_frames();
        t_ack();
        t_refuse();
        t_pending();
        complete_run();
    end

    // whole run needs about 6400 cycles; a hang is cut well beyond that
    initial begin
        repeat (60000) @(posedge clk);
        failures++;
        complete_run();
    end
endmodule // test_opv_rx
